/* File: rtl/dcur_routing.v */
// Notes on behaviour
// - Device holds a 5-bit address, one of up to 32 chain members.
// - Two-bit chain_port_config selects loopback, alert or dual-path routing.
// - In both loopback modes the down path only buffers and retransmits.
// - External loopback mode: down path commands are never decoded.
// - Up path: lower receive bit is resent from the upper transmitter.
// - In both loopback modes upper receive data is resent at once from the lower transmitter.
// - Config 0b01 feeds upper transmit stream into upper receiver internally.
// - Internal loopback takes effect at once; external upper inputs ignored.
// - The selecting write is cut short on its way back down.
`timescale 1ns/1ps
`include "dcur_consts.vh"

// ****************************************
// Pin synchroniser
// ****************************************
// Resets to the idle line level, so no false start bit follows reset.
// Needs at least two stages; only the last stage is read outside.
module dcur_sync #(
   parameter STAGES = `DCUR_SYNC_STAGES,
   parameter [0:0] RESET_VAL = `DCUR_LINE_IDLE
) (
   input wire clock,
   input wire rst_b,
   input wire pin_in,
   output wire pin_sync
);
   reg [STAGES-1:0] stage_r;
   wire [STAGES-1:0] stage_nxt;

   assign stage_nxt = {stage_r[STAGES-2:0], pin_in};

   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         stage_r <= {STAGES{RESET_VAL}};
      end else begin
         stage_r <= stage_nxt;
      end
   end

   assign pin_sync = stage_r[STAGES-1];
endmodule // dcur_sync

// ****************************************
// Port routing
// ****************************************
module dcur_routing #(
   parameter ADDR_W = `DCUR_ADDR_W
) (
   input wire clock,
   input wire rst_b,
   input wire [1:0] chain_port_config,
   input wire [ADDR_W-1:0] dev_addr,
   input wire rx_lower,
   input wire rx_upper,
   input wire alert_bit,
   input wire dual_tx_bit,
   output wire tx_upper,
   output wire tx_lower,
   output wire up_rx_data,
   output wire down_rx_data,
   output wire down_decode_en,
   output reg [ADDR_W-1:0] addr_r
);
   // ****************************************
   // Mode decode
   // ****************************************
   wire mode_int_loop;
   wire mode_dual;

   // Config is a level on our own clock, so it acts at the next edge
   assign mode_int_loop = (chain_port_config == `DCUR_CFG_INT_LOOP);
   assign mode_dual = (chain_port_config == `DCUR_CFG_DUAL);

   // ****************************************
   // Pin synchronisers
   // ****************************************
   wire rx_lower_sync;
   wire rx_upper_sync;

   dcur_sync i_sync_lower (
      .clock(clock),
      .rst_b(rst_b),
      .pin_in(rx_lower),
      .pin_sync(rx_lower_sync)
   );

   dcur_sync i_sync_upper (
      .clock(clock),
      .rst_b(rst_b),
      .pin_in(rx_upper),
      .pin_sync(rx_upper_sync)
   );

   // ****************************************
   // Up path
   // ****************************************
   reg tx_upper_r;
   reg tx_upper_nxt;

   always @* begin
      tx_upper_nxt = rx_lower_sync;
   end

   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         tx_upper_r <= `DCUR_LINE_IDLE;
      end else begin
         tx_upper_r <= tx_upper_nxt;
      end
   end

   assign tx_upper = tx_upper_r;

   // ****************************************
   // Upper receiver source
   // ****************************************
   // The loop taps the transmit stream ahead of its flop, so a looped bit
   // takes no longer to return than one that arrives on the cable
   reg up_rx_data_r;
   reg up_rx_data_nxt;

   always @* begin
      // Switching acts at once, so a packet in flight is cut short
      if (mode_int_loop) begin
         up_rx_data_nxt = tx_upper_nxt;
      end else begin
         up_rx_data_nxt = rx_upper_sync;
      end
   end

   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         up_rx_data_r <= `DCUR_LINE_IDLE;
      end else begin
         up_rx_data_r <= up_rx_data_nxt;
      end
   end

   assign up_rx_data = up_rx_data_r;

   // ****************************************
   // Down path
   // ****************************************
   reg tx_lower_r;
   reg tx_lower_nxt;
   reg down_rx_data_r;
   reg down_rx_data_nxt;

   always @* begin
      down_rx_data_nxt = up_rx_data_nxt;
      case (chain_port_config)
         `DCUR_CFG_EXT_LOOP: begin
            tx_lower_nxt = up_rx_data_nxt;
         end
         `DCUR_CFG_INT_LOOP: begin
            tx_lower_nxt = up_rx_data_nxt;
         end
         `DCUR_CFG_DIFF_ALERT: begin
            tx_lower_nxt = alert_bit;
         end
         `DCUR_CFG_DUAL: begin
            tx_lower_nxt = dual_tx_bit;
         end
         default: begin
            tx_lower_nxt = up_rx_data_nxt;
         end
      endcase
   end

   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         tx_lower_r <= `DCUR_LINE_IDLE;
      end else begin
         tx_lower_r <= tx_lower_nxt;
      end
   end

   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         down_rx_data_r <= `DCUR_LINE_IDLE;
      end else begin
         down_rx_data_r <= down_rx_data_nxt;
      end
   end

   assign tx_lower = tx_lower_r;
   assign down_rx_data = down_rx_data_r;

   // ****************************************
   // Down path decode enable
   // ****************************************
   reg down_decode_en_r;
   reg down_decode_en_nxt;

   always @* begin
      // Loopback modes only resend; commands there must never execute
      down_decode_en_nxt = mode_dual;
   end

   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         down_decode_en_r <= `DCUR_DECODE_OFF;
      end else begin
         down_decode_en_r <= down_decode_en_nxt;
      end
   end

   assign down_decode_en = down_decode_en_r;

   // ****************************************
   // Device address
   // ****************************************
   reg [ADDR_W-1:0] addr_nxt;

   always @* begin
      addr_nxt = dev_addr;
   end

   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         addr_r <= {ADDR_W{`DCUR_ADDR_RESET}};
      end else begin
         addr_r <= addr_nxt;
      end
   end
endmodule // dcur_routing

/* File: rtl/dcur_consts.vh */
`ifndef DCUR_CONSTS_VH
`define DCUR_CONSTS_VH
// ****************************************
// Chain port configuration codes
// ****************************************
`define DCUR_CFG_EXT_LOOP 2'h0
`define DCUR_CFG_INT_LOOP 2'h1
`define DCUR_CFG_DIFF_ALERT 2'h2
`define DCUR_CFG_DUAL 2'h3
`define DCUR_CFG_RESET 2'h0
// ****************************************
// Reset and idle levels
// ****************************************
`define DCUR_LINE_IDLE 1'h1
`define DCUR_DECODE_OFF 1'h0
`define DCUR_ADDR_RESET 1'h0
// ****************************************
// Timing
// ****************************************
`define DCUR_SYNC_STAGES 2
// ****************************************
// Addressing
// ****************************************
`define DCUR_MAX_DEVICES 32
`define DCUR_ADDR_W 5
`endif

/* File: test/dcur_routing_props.sv */
`timescale 1ns/1ps
module dcur_routing_props #(parameter ADDR_W = 5) (
input wire clock, rst_b, rx_lower, rx_upper, alert_bit, dual_tx_bit,
input wire [1:0] chain_port_config, input wire [ADDR_W-1:0] dev_addr,
input wire tx_upper, tx_lower, up_rx_data, down_rx_data, down_decode_en,
input wire [ADDR_W-1:0] addr_r);
wire [1:0] m = chain_port_config;
default clocking @(posedge clock); endclocking
default disable iff (!rst_b);
chk_up_resend: assert property (tx_upper == $past(rx_lower, 3))
   else $error("up");
chk_ext_loop: assert property ($past(m) == 0 |->
   tx_lower == $past(rx_upper, 3)) else $error("ext");
chk_int_loop: assert property ($past(m) == 1 |->
   tx_lower == $past(rx_lower, 3)) else $error("int");
chk_alert_down: assert property ($past(m) == 2 |->
   tx_lower == $past(alert_bit)) else $error("alert");
chk_dual_down: assert property ($past(m) == 3 |->
   tx_lower == $past(dual_tx_bit)) else $error("dual");
chk_no_decode: assert property ($past(m) != 3 |->
   !down_decode_en) else $error("dec");
chk_decode_on: assert property ($past(m) == 3 |->
   down_decode_en) else $error("dec on");
chk_addr_hold: assert property ($past(rst_b) |->
   addr_r == $past(dev_addr)) else $error("addr");
chk_int_rx: assert property ($past(m) == 1 |->
   up_rx_data == $past(rx_lower, 3)) else $error("rx");
chk_loop_cut: assert property ($past(m) == 1 |->
   down_rx_data == $past(rx_lower, 3)) else $error("cut");
chk_up_source: assert property ($past(m) != 1 |->
   up_rx_data == $past(rx_upper, 3)) else $error("src");
cover property (m == 1 && $fell(tx_upper));
cover property (m == 2 && tx_lower != tx_upper);
cover property (down_decode_en);
endmodule // dcur_routing_props
bind dcur_routing dcur_routing_props #(.ADDR_W(ADDR_W)) i_props(.*);

/* File: test/dcur_peer.sv */
`timescale 1ns/1ps
module dcur_peer (input wire clock, input wire loop_en,
input wire tx_upper, output logic rx_upper);
logic junk_r = 1'b0;
always @(posedge clock) junk_r <= ~junk_r;
// No cable: a changing pattern, so a stale bit cannot pass
assign rx_upper = loop_en ? tx_upper : junk_r;
endmodule // dcur_peer

/* File: test/tb_daisy_chain_uart_routing.sv */
`timescale 1ns/1ps
module tb_daisy_chain_uart_routing;
logic clock = 0, rst_b = 0, rx = 1;
logic [1:0] cfg = 0;
logic [4:0] addr = 5'h1f;
logic rx_upper, tx_upper, tx_lower, up_rx, down_rx, dec_en;
logic [4:0] addr_seen;
integer failures = 0, check_count = 0;
initial forever #4 clock = ~clock;
// Cable on the top port except in internal loopback: broken link harmless
dcur_peer i_peer (.clock(clock), .loop_en(cfg != 2'h1),
   .tx_upper(tx_upper), .rx_upper(rx_upper));
dcur_routing i_dut (.clock(clock), .rst_b(rst_b), .chain_port_config(cfg),
   .dev_addr(addr), .rx_lower(rx), .rx_upper(rx_upper),
   .alert_bit(~rx), .dual_tx_bit(rx), .tx_upper(tx_upper),
   .tx_lower(tx_lower), .up_rx_data(up_rx), .down_rx_data(down_rx),
   .down_decode_en(dec_en), .addr_r(addr_seen));
task chk(input logic [4:0] seen, exp);
   check_count++;
   if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen %h exp %h", $time, seen, exp);
   end
endtask
task final_report;
   $display("checks %0d bad %0d", check_count, failures);
   if (failures == 0 && check_count > 0) $display("verification passed");
   else $display("verification failed");
   $finish;
endtask
task run_mode(input logic [1:0] m);
   cfg = m;
   addr = {m, 3'h7};
   @(posedge clock);
   #1 cfg = m;
   for (int b = 0; b < 2; b++) begin
      rx = b[0];
      repeat (6) @(posedge clock);
      #1 chk(tx_upper, b[0]);
      chk(tx_lower, b[0] ^ (m == 2'h2));
      chk(up_rx, b[0]);
      chk(down_rx, b[0]);
      chk(dec_en, m == 2'h3);
      chk(addr_seen, {m, 3'h7});
   end
   $display("mode %0d done", m);
endtask
initial begin
   repeat (5) @(posedge clock);
   #1 rst_b = 1;
   for (int i = 0; i < 4; i++) run_mode(i[1:0]);
   final_report;
end
endmodule // tb_daisy_chain_uart_routing
